// [uhcm_defines.svh]
// constants for the host control modes register block
// assumes inclusion by the package and by every design file
`ifndef UHCM_DEFINES_SVH
`define UHCM_DEFINES_SVH

// ***********************************************
// register placement
// ***********************************************
`define UHCM_CTRL_OFFSET   8'h04
`define UHCM_CTRL_RESET    32'h0000_0000
`define UHCM_READ_ZERO     32'h0000_0000

// ***********************************************
// field positions
// ***********************************************
`define UHCM_BIT_WAKE_EN   10
`define UHCM_BIT_WAKE_CON  9
`define UHCM_BIT_ROUTE     8
`define UHCM_FS_HI         7
`define UHCM_FS_LO         6
`define UHCM_BIT_BULK      5
`define UHCM_BIT_CTRL      4
`define UHCM_BIT_ISO       3
`define UHCM_BIT_PER       2
`define UHCM_RATIO_HI      1
`define UHCM_RATIO_LO      0

// ***********************************************
// timing
// ***********************************************
`define UHCM_FRAME_TIME_NS 1000000
`define UHCM_CLK_PERIOD_NS 8
`define UHCM_FRAME_CYCLES  (`UHCM_FRAME_TIME_NS / `UHCM_CLK_PERIOD_NS)
`define UHCM_CNT_ONE       17'h00001
`define UHCM_CNT_ZERO      17'h00000
`define UHCM_RATIO_ZERO    2'h0
`define UHCM_RATIO_ONE     2'h1
`define UHCM_COUNT_ZERO    3'h0
`define UHCM_COUNT_ONE     3'h1

`endif

// [uhcm_pkg.sv]
// types shared by the host control modes block
// assumes the defines header is on the include path
`include "uhcm_defines.svh"

package uhcm_pkg;

    // functional state encoding as seen in the register
    typedef enum logic [1:0] {
        STATE_RESET       = 2'b00,
        STATE_RESUME      = 2'b01,
        STATE_OPERATIONAL = 2'b10,
        STATE_SUSPEND     = 2'b11
    } uhcm_state_t;

endpackage

// [uhcm_frame_timer.sv]
// frame timer: first frame start one frame period plus one cycle after restart,
// then one start pulse each frame period while running
// assumes restart and run come from the control register block
`timescale 1ns/1ns
`include "uhcm_defines.svh"

module uhcm_frame_timer #(
    parameter int FRAME_CYCLES = `UHCM_FRAME_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic restart,
    input  wire logic run,
    output logic      sofPulse
);
    import uhcm_pkg::*;

    // ***********************************************
    // frame counter
    // ***********************************************
    logic [16:0] count;       // cycles left in the current frame
    logic [16:0] next_count;
    logic        next_sofPulse;

    localparam logic [16:0] LOAD = 17'(FRAME_CYCLES);

    // next values: restart reloads a whole period, so the first start
    // lands one frame plus one cycle after entering operation
    always_comb begin
        next_count    = count;
        next_sofPulse = 1'b0;
        if (restart || !run) begin
            next_count = LOAD;
        end else if (count == `UHCM_CNT_ONE) begin
            next_count    = LOAD;
            next_sofPulse = 1'b1;
        end else begin
            next_count = count - `UHCM_CNT_ONE;
        end
    end

    // registers only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count    <= `UHCM_CNT_ZERO;
            sofPulse <= 1'b0;
        end else begin
            count    <= next_count;
            sofPulse <= next_sofPulse;
        end
    end

endmodule

// [uhcm_control_modes.sv]
// host control modes register with functional state machine,
// interrupt routing, wake-up signalling and list enable gating
// assumes a simple register port at the documented offset and list
// engines that request permission before each list they start
//
// Behaviour
// - wake enable and resume detected signal wake-up
// - wake enable never gates hardware interrupts
// - wake connected cleared by hard reset only
// - route bit selects normal or management interrupt
// - route bit cleared by hard reset only
// - state field codes reset resume operational suspend
// - frame starts begin one millisecond after operational
// - hardware changes state only while suspended
// - suspend moves to resume on downstream resume
// - soft reset gives suspend, hard reset gives reset
// - hard reset resets root hub then ports
// - bulk enable takes effect at frame boundary
// - bulk enable sampled at each bulk attempt
// - control enable takes effect at frame boundary
// - iso disabled halts periodic, moves to nonperiodic
// - periodic enable checked before list starts
// - control to bulk ratio count kept across frames
`timescale 1ns/1ns
`include "uhcm_defines.svh"

module uhcm_control_modes #(
    parameter int FRAME_CYCLES = `UHCM_FRAME_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        softReset,
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    input  wire logic        resumeDetected,
    input  wire logic        downstreamResume,
    input  wire logic        statusIrq,
    input  wire logic        controlReq,
    input  wire logic        bulkReq,
    input  wire logic        periodicReq,
    input  wire logic        isoDescSeen,
    input  wire logic        controlServed,
    input  wire logic        bulkServed,
    output logic             hostIrq,
    output logic             smiIrq,
    output logic             remoteWake,
    output logic             rootHubReset,
    output logic             portResetDrive,
    output logic             frameStartFlag,
    output logic             controlGo,
    output logic             bulkGo,
    output logic             periodicGo,
    output logic             isoHalt,
    output logic             pickControl,
    output uhcm_pkg::uhcm_state_t functionalState
);
    import uhcm_pkg::*;

    // ***********************************************
    // register fields and state
    // ***********************************************
    logic        wakeEnable;     // wake_enable_bit
    logic        wakeConnected;  // wake_connected_bit
    logic        routeSelect;    // interrupt_route_select
    logic        bulkEnable;     // bulk_list_enable
    logic        ctrlEnable;     // control list enable
    logic        isoEnable;      // isochronous_enable
    logic        perEnable;      // periodic_list_enable
    logic [1:0]  ratio;          // control_bulk_ratio
    // three bits: at 4:1 the count reaches four and must not wrap to zero
    logic [2:0]  ctrlCount;      // control descriptors served in a row
    logic        frameBulk;      // enables latched at last frame start
    logic        frameCtrl;
    logic        frameIso;
    logic        framePer;
    uhcm_state_t prevState;      // for entry detection
    logic        ctrlHit;        // write strobe to our register

    logic        next_wakeEnable;
    logic        next_wakeConnected;
    logic        next_routeSelect;
    logic        next_bulkEnable;
    logic        next_ctrlEnable;
    logic        next_isoEnable;
    logic        next_perEnable;
    logic [1:0]  next_ratio;
    logic [2:0]  next_ctrlCount;
    uhcm_state_t next_state;
    logic        next_frameBulk;
    logic        next_frameCtrl;
    logic        next_frameIso;
    logic        next_framePer;
    logic [31:0] next_regRdata;
    logic        sofPulse;       // frame start from the timer
    logic        enterOper;      // first cycle in operational

    assign ctrlHit = regWrite && (regAddr == `UHCM_CTRL_OFFSET);

    // ***********************************************
    // register and state next values
    // ***********************************************
    // a software write wins over the autonomous resume move; the
    // driver owns the field whenever it writes it
    always_comb begin
        next_wakeEnable    = wakeEnable;
        next_wakeConnected = wakeConnected;
        next_routeSelect   = routeSelect;
        next_bulkEnable    = bulkEnable;
        next_ctrlEnable    = ctrlEnable;
        next_isoEnable     = isoEnable;
        next_perEnable     = perEnable;
        next_ratio         = ratio;
        next_state         = functionalState;
        if (softReset) begin
            // wake connected and routing survive a soft reset
            next_wakeEnable = 1'b0;
            next_bulkEnable = 1'b0;
            next_ctrlEnable = 1'b0;
            next_isoEnable  = 1'b0;
            next_perEnable  = 1'b0;
            next_ratio      = `UHCM_RATIO_ZERO;
            next_state      = STATE_SUSPEND;
        end else if (ctrlHit) begin
            // every field stored as written
            next_wakeEnable    = regWdata[`UHCM_BIT_WAKE_EN];
            next_wakeConnected = regWdata[`UHCM_BIT_WAKE_CON];
            next_routeSelect   = regWdata[`UHCM_BIT_ROUTE];
            next_bulkEnable    = regWdata[`UHCM_BIT_BULK];
            next_ctrlEnable    = regWdata[`UHCM_BIT_CTRL];
            next_isoEnable     = regWdata[`UHCM_BIT_ISO];
            next_perEnable     = regWdata[`UHCM_BIT_PER];
            next_ratio = regWdata[`UHCM_RATIO_HI:`UHCM_RATIO_LO];
            next_state = uhcm_state_t'(regWdata[`UHCM_FS_HI:`UHCM_FS_LO]);
        end else begin
            // own moves only out of suspend
            unique case (functionalState)
                STATE_SUSPEND: begin
                    if (downstreamResume) begin
                        next_state = STATE_RESUME;
                    end
                end
                STATE_RESET,
                STATE_RESUME,
                STATE_OPERATIONAL: begin
                    next_state = functionalState;
                end
            endcase
        end
    end

    // ***********************************************
    // list enables, ratio count and read data
    // ***********************************************
    // enables are copied at each frame start so setting one lands on the
    // next frame; clearing one acts at once through the live bit gating
    always_comb begin
        next_frameBulk = frameBulk;
        next_frameCtrl = frameCtrl;
        next_frameIso  = frameIso;
        next_framePer  = framePer;
        next_ctrlCount = ctrlCount;
        if (sofPulse) begin
            next_frameBulk = bulkEnable;
            next_frameCtrl = ctrlEnable;
            next_frameIso  = isoEnable;
            next_framePer  = perEnable;
        end
        // count not touched by frame starts
        if (bulkServed) begin
            next_ctrlCount = `UHCM_COUNT_ZERO;
        end else if (controlServed && pickControl) begin
            next_ctrlCount = ctrlCount + `UHCM_COUNT_ONE;
        end
        // reads have no side effect; one cycle latency
        next_regRdata = `UHCM_READ_ZERO;
        if (regAddr == `UHCM_CTRL_OFFSET) begin
            next_regRdata[`UHCM_BIT_WAKE_EN]  = wakeEnable;
            next_regRdata[`UHCM_BIT_WAKE_CON] = wakeConnected;
            next_regRdata[`UHCM_BIT_ROUTE]    = routeSelect;
            next_regRdata[`UHCM_FS_HI:`UHCM_FS_LO] = functionalState;
            next_regRdata[`UHCM_BIT_BULK]     = bulkEnable;
            next_regRdata[`UHCM_BIT_CTRL]     = ctrlEnable;
            next_regRdata[`UHCM_BIT_ISO]      = isoEnable;
            next_regRdata[`UHCM_BIT_PER]      = perEnable;
            next_regRdata[`UHCM_RATIO_HI:`UHCM_RATIO_LO] = ratio;
        end
    end

    // registers only; hard reset clears connected and routing
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wakeEnable      <= 1'b0;
            wakeConnected   <= 1'b0;
            routeSelect     <= 1'b0;
            bulkEnable      <= 1'b0;
            ctrlEnable      <= 1'b0;
            isoEnable       <= 1'b0;
            perEnable       <= 1'b0;
            ratio           <= `UHCM_RATIO_ZERO;
            functionalState <= STATE_RESET;
            prevState       <= STATE_RESET;
            frameBulk       <= 1'b0;
            frameCtrl       <= 1'b0;
            frameIso        <= 1'b0;
            framePer        <= 1'b0;
            ctrlCount       <= `UHCM_COUNT_ZERO;
            regRdata        <= `UHCM_CTRL_RESET;
            rootHubReset    <= 1'b1;
        end else begin
            wakeEnable      <= next_wakeEnable;
            wakeConnected   <= next_wakeConnected;
            routeSelect     <= next_routeSelect;
            bulkEnable      <= next_bulkEnable;
            ctrlEnable      <= next_ctrlEnable;
            isoEnable       <= next_isoEnable;
            perEnable       <= next_perEnable;
            ratio           <= next_ratio;
            functionalState <= next_state;
            prevState       <= functionalState;
            frameBulk       <= next_frameBulk;
            frameCtrl       <= next_frameCtrl;
            frameIso        <= next_frameIso;
            framePer        <= next_framePer;
            ctrlCount       <= next_ctrlCount;
            regRdata        <= next_regRdata;
            rootHubReset    <= 1'b0;
        end
    end

    // ***********************************************
    // frame generation
    // ***********************************************
    // entry from any other state restarts the one frame delay
    assign enterOper = (functionalState == STATE_OPERATIONAL)
                    && (prevState != STATE_OPERATIONAL);

    uhcm_frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) uhcm_frame_timer_inst (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .restart  (enterOper),
        .run      (functionalState == STATE_OPERATIONAL),
        .sofPulse (sofPulse)
    );

    // ***********************************************
    // outputs
    // ***********************************************
    // wake enable takes no part in the interrupt path
    assign hostIrq = statusIrq && !routeSelect;
    assign smiIrq  = statusIrq && routeSelect;
    assign remoteWake = wakeEnable && resumeDetected;
    // ports are driven into reset only after the root hub pulse
    assign portResetDrive = (functionalState == STATE_RESET)
                         && !rootHubReset;
    assign frameStartFlag = sofPulse;
    // live bit checked on every attempt, frame copy gives boundary
    assign bulkGo     = bulkReq && bulkEnable && frameBulk;
    assign controlGo  = controlReq && ctrlEnable && frameCtrl;
    assign periodicGo = periodicReq && perEnable && framePer;
    assign isoHalt    = isoDescSeen && !(isoEnable && frameIso);
    // keep serving control until ratio plus one served
    assign pickControl = (ctrlCount <= {1'b0, ratio});

    // ***********************************************
    // checks
    // ***********************************************
    wake_signal_a: assert property (@(posedge sys_clk) disable iff (reset)
        remoteWake == (wakeEnable && resumeDetected))
        else $error("remote wake does not follow enable and resume");
    irq_nowake_a: assert property (@(posedge sys_clk) disable iff (reset)
        statusIrq |-> (hostIrq || smiIrq))
        else $error("status event lost from interrupt outputs");
    soft_keep_a: assert property (@(posedge sys_clk) disable iff (reset)
        softReset |=> $stable(wakeConnected) && $stable(routeSelect)
        && functionalState == STATE_SUSPEND)
        else $error("soft reset altered kept bits or state");
    irq_route_a: assert property (@(posedge sys_clk) disable iff (reset)
        statusIrq |-> (smiIrq == routeSelect) && (hostIrq != smiIrq))
        else $error("interrupt sent to wrong destination");
    route_write_a: assert property (@(posedge sys_clk) disable iff (reset)
        ctrlHit && !softReset |=>
        routeSelect == $past(regWdata[`UHCM_BIT_ROUTE]))
        else $error("route bit not held as written");
    state_auto_a: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrlHit && !softReset && functionalState != STATE_SUSPEND
        |=> $stable(functionalState))
        else $error("state changed by hardware outside suspend");
    resume_move_a: assert property (@(posedge sys_clk) disable iff (reset)
        functionalState == STATE_SUSPEND && downstreamResume
        && !ctrlHit && !softReset |=> functionalState == STATE_RESUME)
        else $error("no move to resume from suspend");
    first_sof_a: assert property (@(posedge sys_clk) disable iff (reset)
        enterOper |-> !sofPulse [*2])
        else $error("frame start too soon after entering operation");
    bulk_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
        bulkGo |-> bulkEnable && frameBulk)
        else $error("bulk granted while disabled");
    ratio_pick_a: assert property (@(posedge sys_clk) disable iff (reset)
        sofPulse && !bulkServed && !controlServed |=> $stable(ctrlCount))
        else $error("ratio count lost at frame boundary");
    iso_halt_a: assert property (@(posedge sys_clk) disable iff (reset)
        isoDescSeen && !isoEnable |-> isoHalt)
        else $error("iso descriptor processed while disabled");

endmodule

// [test_usb_host_control_modes.sv]
// self-checking bench for the host control modes register block
// assumes the defines header and the state package are compiled first
`timescale 1ns/1ns

module test_usb_host_control_modes;
    import uhcm_pkg::*;

    // ***********************************************
    // signals
    // ***********************************************
    // a short frame keeps the run brief; expectations derive from it
    localparam int FRAME_LEN = 20;
    localparam logic [7:0] REG_AT = 8'h04; // control register offset
    logic        sys_clk          = 1'b0;
    logic        reset            = 1'b1;  // held from time zero
    logic        softReset        = 1'b0;
    logic [7:0]  regAddr          = 8'h00;
    logic        regWrite         = 1'b0;
    logic [31:0] regWdata         = 32'h0000_0000;
    logic [31:0] regRdata;
    logic        resumeDetected   = 1'b0;
    logic        downstreamResume = 1'b0;
    logic        statusIrq        = 1'b0;
    logic        controlReq       = 1'b0;
    logic        bulkReq          = 1'b0;
    logic        periodicReq      = 1'b0;
    logic        isoDescSeen      = 1'b0;
    logic        controlServed    = 1'b0;
    logic        bulkServed       = 1'b0;
    logic        hostIrq, smiIrq, remoteWake, rootHubReset, portResetDrive;
    logic        frameStartFlag, controlGo, bulkGo, periodicGo;
    logic        isoHalt, pickControl;
    uhcm_state_t functionalState;
    int          failures = 0;     // mismatches seen
    int          checked  = 0;     // comparisons made

    always #4 sys_clk = ~sys_clk;  // 125 MHz

    uhcm_control_modes #(.FRAME_CYCLES(FRAME_LEN)) uhcm_control_modes_inst (
        .sys_clk(sys_clk), .reset(reset), .softReset(softReset),
        .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
        .regRdata(regRdata), .resumeDetected(resumeDetected),
        .downstreamResume(downstreamResume), .statusIrq(statusIrq),
        .controlReq(controlReq), .bulkReq(bulkReq),
        .periodicReq(periodicReq), .isoDescSeen(isoDescSeen),
        .controlServed(controlServed), .bulkServed(bulkServed),
        .hostIrq(hostIrq), .smiIrq(smiIrq), .remoteWake(remoteWake),
        .rootHubReset(rootHubReset), .portResetDrive(portResetDrive),
        .frameStartFlag(frameStartFlag), .controlGo(controlGo),
        .bulkGo(bulkGo), .periodicGo(periodicGo), .isoHalt(isoHalt),
        .pickControl(pickControl), .functionalState(functionalState));

    // ***********************************************
    // compare and access tasks
    // ***********************************************
    task automatic chk_bit(input string name, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_word(input string name, input logic [31:0] e,
                            input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_state(input uhcm_state_t e);
        checked++;
        if (functionalState !== e) begin
            failures++;
            $display("wrong value state expected %h seen %h", e,
                     functionalState);
        end
    endtask

    // let n edges pass, then sample where outputs have settled
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one-cycle write strobe; fields visible once this returns
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWrite <= 1'b1;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask

    // read data lags the address by one edge; two edges for margin
    task automatic read_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        step(2);
        chk_word("read data", e, regRdata);
    endtask

    task automatic pulse_soft();
        @(posedge sys_clk);
        softReset <= 1'b1;
        @(posedge sys_clk);
        softReset <= 1'b0;
        #1;
    endtask

    // one served descriptor, control or bulk
    task automatic served(input logic ctl);
        @(posedge sys_clk);
        controlServed <= ctl;
        bulkServed    <= !ctl;
        @(posedge sys_clk);
        controlServed <= 1'b0;
        bulkServed    <= 1'b0;
        #1;
    endtask

    // hard reset of n+1 cycles, then the root hub and port sequence
    task automatic hard_reset(input int n);
        @(posedge sys_clk);
        reset <= 1'b1;
        step(n);
        chk_bit("hub reset", 1'b1, rootHubReset);
        chk_bit("port reset", 1'b0, portResetDrive);
        @(posedge sys_clk);
        reset <= 1'b0;
        step(1);
        chk_bit("hub reset", 1'b0, rootHubReset);
        chk_bit("port reset", 1'b1, portResetDrive);
        chk_state(STATE_RESET);
    endtask

    task automatic test_done();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ***********************************************
    // watchdog
    // ***********************************************
    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        test_done();
    end

    // ***********************************************
    // main sequence
    // ***********************************************
    initial begin
        logic [31:0] v;
        hard_reset(6);
        read_chk(REG_AT, 32'h0000_0000);
        // reserved bits are dropped; other offsets ignored
        write_reg(REG_AT, 32'hFFFF_FD00);
        read_chk(REG_AT, 32'h0000_0500);
        write_reg(8'h08, 32'h0000_0000);
        read_chk(REG_AT, 32'h0000_0500);
        read_chk(8'h08, 32'h0000_0000);
        // wake and routing combinations with an event pending
        @(posedge sys_clk);
        statusIrq      <= 1'b1;
        resumeDetected <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = {21'h0, i[1], 1'b0, i[0], 8'h00};
            write_reg(REG_AT, v);
            chk_bit("wake", v[10], remoteWake);
            chk_bit("host irq", ~v[8], hostIrq);
            chk_bit("smi irq", v[8], smiIrq);
        end
        // soft reset keeps connect and route, forces suspend
        write_reg(REG_AT, 32'h0000_0783);
        pulse_soft();
        chk_state(STATE_SUSPEND);
        read_chk(REG_AT, 32'h0000_03C0);
        @(posedge sys_clk);
        downstreamResume <= 1'b1;
        step(2);
        chk_state(STATE_RESUME);
        // resume to operational: frame starts after the delay
        write_reg(REG_AT, 32'h0000_0380);
        step(FRAME_LEN);
        chk_bit("frame start", 1'b0, frameStartFlag);
        step(1);
        chk_bit("frame start", 1'b1, frameStartFlag);
        step(1);
        chk_bit("frame start", 1'b0, frameStartFlag);
        step(FRAME_LEN - 1);
        chk_bit("frame start", 1'b1, frameStartFlag);
        chk_state(STATE_OPERATIONAL);
        @(posedge sys_clk);
        downstreamResume <= 1'b0;
        // list enables wait for the next frame start
        controlReq  <= 1'b1;
        bulkReq     <= 1'b1;
        periodicReq <= 1'b1;
        isoDescSeen <= 1'b1;
        write_reg(REG_AT, 32'h0000_03BC);
        chk_bit("bulk go", 1'b0, bulkGo);
        chk_bit("control go", 1'b0, controlGo);
        for (int i = 0; i < 2 * FRAME_LEN && frameStartFlag !== 1'b1; i++)
            step(1);
        chk_bit("frame start", 1'b1, frameStartFlag);
        step(1);
        chk_bit("bulk go", 1'b1, bulkGo);
        chk_bit("control go", 1'b1, controlGo);
        chk_bit("periodic go", 1'b1, periodicGo);
        chk_bit("iso halt", 1'b0, isoHalt);
        // clearing takes hold for the next attempt
        write_reg(REG_AT, 32'h0000_0380);
        // list edits by software are safe only from here on
        chk_bit("bulk go", 1'b0, bulkGo);
        chk_bit("control go", 1'b0, controlGo);
        chk_bit("periodic go", 1'b0, periodicGo);
        chk_bit("iso halt", 1'b1, isoHalt);
        // every service ratio: r+1 control picks, then bulk
        for (int r = 0; r < 4; r++) begin
            write_reg(REG_AT, 32'h0000_0380 | r);
            served(1'b0);
            for (int k = 0; k <= r + 1; k++) begin
                chk_bit("pick control", k <= r, pickControl);
                if (k <= r) served(1'b1);
            end
        end
        hard_reset(3);
        read_chk(REG_AT, 32'h0000_0000);
        test_done();
    end
endmodule
